//--- codec_serial_control_power.sv
// Control side of a PCM voice codec: APB registers, serial control port,
// power sequencing, master clock loss detection and voice slot shifting.
// Assumes the serial port, strap, master clock, frame sync and receive pins are asynchronous to pclk and are synchronised here.
// Functional notes
// - Shift control/status bits out on falling shift clock edges while select low.
// - Sample serial input on rising shift clock edges while select low.
// - Shift clock is asynchronous; it is synchronised and edge detected.
// - Transfer control data only while select is held low.
// - Four address straps give bits C4..C7 of the first address byte; here they are only captured and read back in the status register.
// - Reset powers down, loads defaults, disables codec, latches interface strap.
// - Power bit 0 powers up, 1 powers down when an instruction is accepted.
// - After power up keep transmit output off until the second frame sync.
// - Power down keeps registers; registers writable in both power states.
// - Lost master clock forces reset power down, transmit and latch outputs off.
// - Path-select bit 7 picks the microphone pair.
// - Transmit-gain bits 4..7 set second-stage gain 0..15 dB.
// - Transmit enable low grounds transmit input and disables sidetone.
// - Two law bits choose companding law for encode and decode.
// - Encode byte shifts out in the selected transmit slot on rising edges; here always the slot that starts at frame sync.
// - Receive byte shifts in over 8 edges in the selected receive slot; here always the slot that starts at frame sync.
// - Path bits 1,0 route earpiece/speaker; another bit routes handsfree.
// - Attenuation bits 4..7 set earpiece attenuation 0..-15 dB.
// - Transmit-gain bits 0..3 set sidetone; tone bits 4..7 set tone level.
// - Attenuation bits 0..3 set loudspeaker attenuation 0..-30 dB.
// - Serial output is high impedance while select is high.
// - Instructions are two bytes except single-byte power command.
// - Interface strap high picks slot mode with serial port, low picks bus mode.
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module codec_serial_control_power
  import codec_ctrl_pkg::*;
#(
  parameter int MCLK_LOSS_LIMIT = MCLK_LOSS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctrl_shift_clock,
  input wire logic ctrl_select_n,
  input wire logic ctrl_serial_in,
  output logic ctrl_serial_out,
  output logic ctrl_serial_out_oe_n,
  input wire logic [3:0] bus_address_straps,
  input wire logic interface_select_strap,
  input wire logic master_bit_clock,
  input wire logic frame_sync,
  input wire logic rx_data_in,
  output logic tx_data_out,
  output logic tx_data_out_oe_n,
  output logic open_drain_latch_out,
  output logic open_drain_latch_out_oe_n,
  input wire logic [7:0] encoded_sample,
  output logic [7:0] received_sample,
  output logic received_valid,
  output logic powered_up,
  output analog_ctrl_s analog_ctrl
);

  // Limit must fit the 16-bit idle counter
  if (MCLK_LOSS_LIMIT < 2 || MCLK_LOSS_LIMIT > 65535) begin : g_bad_limit
    $error("MCLK_LOSS_LIMIT out of range");
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  ctrl_port_s port_meta, port_sync, port_prev;
  logic [1:0] mclk_meta, mclk_sync;
  logic [1:0] fs_meta, fs_sync;
  logic [1:0] rx_meta, rx_sync;
  logic [4:0] strap_meta, strap_sync;
  logic mclk_prev, fs_prev;
  // Idle pin levels, so no false shift clock edge or select follows reset
  localparam ctrl_port_s PORT_IDLE = '{shift_clock: 1'b0, select_n: 1'b1, serial_in: 1'b1};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_meta <= PORT_IDLE;
      port_sync <= PORT_IDLE;
      port_prev <= PORT_IDLE;
      mclk_meta <= '0;
      mclk_sync <= '0;
      fs_meta <= '0;
      fs_sync <= '0;
      rx_meta <= '0;
      rx_sync <= '0;
      strap_meta <= '0;
      strap_sync <= '0;
      mclk_prev <= 1'b0;
      fs_prev <= 1'b0;
    end else if (clk_en) begin
      port_meta <= '{ctrl_shift_clock, ctrl_select_n, ctrl_serial_in};
      port_sync <= port_meta;
      port_prev <= port_sync;
      mclk_meta <= {mclk_meta[0], master_bit_clock};
      mclk_sync <= {mclk_sync[0], mclk_meta[1]};
      fs_meta <= {fs_meta[0], frame_sync};
      fs_sync <= {fs_sync[0], fs_meta[1]};
      rx_meta <= {rx_meta[0], rx_data_in};
      rx_sync <= {rx_sync[0], rx_meta[1]};
      strap_meta <= {interface_select_strap, bus_address_straps};
      strap_sync <= strap_meta;
      mclk_prev <= mclk_sync[1];
      fs_prev <= fs_sync[1];
    end
  end

  logic sclk_rise, sclk_fall, sel_active;
  logic mclk_rise, mclk_fall, fs_rise;
  assign sel_active = !port_sync.select_n;
  assign sclk_rise = sel_active && port_sync.shift_clock && !port_prev.shift_clock;
  assign sclk_fall = sel_active && !port_sync.shift_clock && port_prev.shift_clock;
  assign mclk_rise = mclk_sync[1] && !mclk_prev;
  assign mclk_fall = !mclk_sync[1] && mclk_prev;
  assign fs_rise = fs_sync[1] && !fs_prev;

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  logic [1:0] strap_wait;
  logic slot_mode;
  logic [3:0] bus_address;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_wait <= 2'd0;
      slot_mode <= 1'b0;
      bus_address <= 4'h0;
    end else if (clk_en && strap_wait != 2'd3) begin
      strap_wait <= strap_wait + 2'd1;
      slot_mode <= strap_sync[4];
      bus_address <= strap_sync[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] law_clock_config_reg, path_select_reg, tx_gain_sidetone_reg;
  logic [7:0] rx_attenuation_reg, tone_level_reg;
  logic power_down;
  logic mclk_lost;
  logic [7:0] serial_last;

  // Serial instruction: byte 1 = {reg index[7:5], 3'b0, read, power}; index 1..3 is one byte
  logic [7:0] shift_in;
  logic [3:0] bit_count;
  logic have_first, reading;
  logic [7:0] first_byte, shift_out;
  logic serial_write, serial_power;
  logic [2:0] serial_index;
  logic [7:0] serial_data;

  function automatic logic [7:0] read_reg(input logic [2:0] idx);
    case (idx)
      3'd0: read_reg = law_clock_config_reg;
      3'd4: read_reg = path_select_reg;
      3'd5: read_reg = tx_gain_sidetone_reg;
      3'd6: read_reg = rx_attenuation_reg;
      3'd7: read_reg = tone_level_reg;
      default: read_reg = READBACK_FILL;
    endcase
  endfunction

  logic apb_write;
  assign apb_write = psel && penable && pwrite;

  // Serial writes win over APB writes in the same cycle; both paths work in
  // either power state since the registers are never gated by it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      law_clock_config_reg <= RESET_LAW_CLOCK_CONFIG;
      path_select_reg <= RESET_PATH_SELECT;
      tx_gain_sidetone_reg <= RESET_TX_GAIN_SIDETONE;
      rx_attenuation_reg <= RESET_RX_ATTENUATION;
      tone_level_reg <= RESET_TONE_LEVEL;
    end else if (clk_en) begin
      if (serial_write) begin
        case (serial_index)
          3'd0: law_clock_config_reg <= serial_data;
          3'd4: path_select_reg <= serial_data;
          3'd5: tx_gain_sidetone_reg <= serial_data;
          3'd6: rx_attenuation_reg <= serial_data;
          3'd7: tone_level_reg <= serial_data;
          default: ;
        endcase
      end else if (apb_write) begin
        case (paddr)
          ADDR_LAW_CLOCK_CONFIG: law_clock_config_reg <= pwdata[7:0];
          ADDR_PATH_SELECT: path_select_reg <= pwdata[7:0];
          ADDR_TX_GAIN_SIDETONE: tx_gain_sidetone_reg <= pwdata[7:0];
          ADDR_RX_ATTENUATION: rx_attenuation_reg <= pwdata[7:0];
          ADDR_TONE_LEVEL: tone_level_reg <= pwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Serial control port
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_in <= 8'h00;
      bit_count <= 4'd0;
      have_first <= 1'b0;
      reading <= 1'b0;
      first_byte <= 8'h00;
      shift_out <= 8'h00;
      serial_write <= 1'b0;
      serial_power <= 1'b0;
      serial_index <= 3'd0;
      serial_data <= 8'h00;
      serial_last <= 8'h00;
      ctrl_serial_out <= 1'b0;
    end else if (clk_en) begin
      serial_write <= 1'b0;
      serial_power <= 1'b0;
      if (!slot_mode) begin
        bit_count <= 4'd0;
        have_first <= 1'b0;
        reading <= 1'b0;
      end else begin
        if (sclk_rise) begin
          shift_in <= {shift_in[6:0], port_sync.serial_in};
          bit_count <= (bit_count == 4'd7) ? 4'd0 : bit_count + 4'd1;
          if (bit_count == 4'd7) begin
            if (reading) begin
              reading <= 1'b0;
              have_first <= 1'b0;
            end else if (!have_first) begin
              first_byte <= {shift_in[6:0], port_sync.serial_in};
              serial_power <= 1'b1;
              if (shift_in[6:4] == 3'd0 || shift_in[6]) begin
                have_first <= 1'b1;
                reading <= shift_in[0];
                shift_out <= read_reg(shift_in[6:4]);
              end
            end else begin
              have_first <= 1'b0;
              serial_write <= 1'b1;
              serial_index <= first_byte[7:5];
              serial_data <= {shift_in[6:0], port_sync.serial_in};
              serial_last <= {shift_in[6:0], port_sync.serial_in};
            end
          end
        end
        if (sclk_fall && reading) begin
          ctrl_serial_out <= shift_out[7];
          shift_out <= {shift_out[6:0], 1'b0};
        end
      end
    end
  end

  // Tristate between select pulses so several devices can share the line
  assign ctrl_serial_out_oe_n = !(slot_mode && sel_active && reading);

  // ----------------------------------------------------------------
  // Power state and clock loss
  // ----------------------------------------------------------------
  logic [15:0] mclk_idle;
  logic [1:0] fs_count;
  logic apb_power_write;
  assign apb_power_write = apb_write && paddr == ADDR_POWER_CTRL;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_idle <= 16'd0;
      mclk_lost <= 1'b1;
    end else if (clk_en) begin
      if (mclk_rise || mclk_fall) begin
        mclk_idle <= 16'd0;
        mclk_lost <= 1'b0;
      end else if (mclk_idle >= 16'(MCLK_LOSS_LIMIT - 1)) begin
        mclk_lost <= 1'b1;
      end else begin
        mclk_idle <= mclk_idle + 16'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_down <= 1'b1;
      fs_count <= 2'd0;
    end else if (clk_en) begin
      if (mclk_lost) begin
        power_down <= 1'b1;
      end else if (serial_power) begin
        power_down <= first_byte[POWER_BIT];
      end else if (apb_power_write) begin
        power_down <= pwdata[POWER_BIT];
      end
      if (power_down || mclk_lost) begin
        fs_count <= 2'd0;
      end else if (fs_rise && fs_count != 2'(FS_PULSES_TO_TX)) begin
        fs_count <= fs_count + 2'd1;
      end
    end
  end

  assign powered_up = !power_down;

  // ----------------------------------------------------------------
  // Voice slot shifting
  // ----------------------------------------------------------------
  logic [3:0] slot_bit;
  logic in_slot;
  logic [7:0] tx_shift, rx_shift;
  logic tx_allowed;
  assign tx_allowed = fs_count == 2'(FS_PULSES_TO_TX) && !mclk_lost;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slot_bit <= 4'd0;
      in_slot <= 1'b0;
      tx_shift <= 8'h00;
      rx_shift <= 8'h00;
      tx_data_out <= 1'b1;
      received_sample <= 8'h00;
      received_valid <= 1'b0;
    end else if (clk_en) begin
      received_valid <= 1'b0;
      if (fs_rise && !power_down) begin
        in_slot <= 1'b1;
        slot_bit <= 4'd0;
        tx_shift <= encoded_sample;
      end else if (in_slot && mclk_rise) begin
        tx_data_out <= tx_shift[7];
        tx_shift <= {tx_shift[6:0], 1'b0};
      end else if (in_slot && mclk_fall) begin
        rx_shift <= {rx_shift[6:0], rx_sync[1]};
        slot_bit <= slot_bit + 4'd1;
        if (slot_bit == 4'(SLOT_BITS - 1)) begin
          in_slot <= 1'b0;
          received_sample <= {rx_shift[6:0], rx_sync[1]};
          received_valid <= 1'b1;
        end
      end
    end
  end

  assign tx_data_out_oe_n = !(in_slot && tx_allowed && !power_down);
  assign open_drain_latch_out = 1'b0;
  assign open_drain_latch_out_oe_n = !(law_clock_config_reg[0] && !mclk_lost);

  // ----------------------------------------------------------------
  // Analog control fields
  // ----------------------------------------------------------------
  always_comb begin
    analog_ctrl.mic_select = path_select_reg[MIC_SELECT_BIT];
    analog_ctrl.tx_gain = tx_gain_sidetone_reg[7:4];
    analog_ctrl.sidetone = tx_gain_sidetone_reg[3:0];
    analog_ctrl.tx_ground = !path_select_reg[TX_ENABLE_BIT] || power_down;
    analog_ctrl.sidetone_enable = path_select_reg[TX_ENABLE_BIT] && !power_down;
    analog_ctrl.ear_atten = rx_attenuation_reg[7:4];
    analog_ctrl.speaker_atten = rx_attenuation_reg[3:0];
    analog_ctrl.tone_level = tone_level_reg[7:4];
    analog_ctrl.earpiece_route = path_select_reg[EARPIECE_BIT];
    analog_ctrl.speaker_route = path_select_reg[SPEAKER_BIT];
    analog_ctrl.handsfree_route = path_select_reg[HANDSFREE_BIT];
    analog_ctrl.law_select = {law_clock_config_reg[LAW_A_BIT],
                              law_clock_config_reg[LAW_B_BIT]};
  end

  // ----------------------------------------------------------------
  // APB read and answer
  // ----------------------------------------------------------------
  logic mapped;
  always_comb begin
    case (paddr)
      ADDR_LAW_CLOCK_CONFIG, ADDR_PATH_SELECT, ADDR_TX_GAIN_SIDETONE,
      ADDR_RX_ATTENUATION, ADDR_TONE_LEVEL, ADDR_POWER_CTRL, ADDR_STATUS,
      ADDR_SERIAL_RX: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (clk_en && psel && !penable && !pwrite) begin
      case (paddr)
        ADDR_LAW_CLOCK_CONFIG: prdata <= {24'h000000, law_clock_config_reg};
        ADDR_PATH_SELECT: prdata <= {24'h000000, path_select_reg};
        ADDR_TX_GAIN_SIDETONE: prdata <= {24'h000000, tx_gain_sidetone_reg};
        ADDR_RX_ATTENUATION: prdata <= {24'h000000, rx_attenuation_reg};
        ADDR_TONE_LEVEL: prdata <= {24'h000000, tone_level_reg};
        ADDR_POWER_CTRL: prdata <= {31'h00000000, power_down};
        ADDR_STATUS: prdata <= {24'h000000, mclk_lost, slot_mode, fs_count, bus_address};
        ADDR_SERIAL_RX: prdata <= {24'h000000, serial_last};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

//--- codec_ctrl_pkg.sv
// Package for the codec control block: register byte addresses, field positions,
// reset values and timing counts.
// Assumes a 125 MHz pclk domain; everything else is sampled into it.
package codec_ctrl_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses on APB
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_LAW_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_PATH_SELECT = 8'h10;
  localparam logic [7:0] ADDR_TX_GAIN_SIDETONE = 8'h14;
  localparam logic [7:0] ADDR_RX_ATTENUATION = 8'h18;
  localparam logic [7:0] ADDR_TONE_LEVEL = 8'h1c;
  localparam logic [7:0] ADDR_POWER_CTRL = 8'h20;
  localparam logic [7:0] ADDR_STATUS = 8'h24;
  localparam logic [7:0] ADDR_SERIAL_RX = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int LAW_A_BIT = 7;
  localparam int LAW_B_BIT = 6;
  localparam int MIC_SELECT_BIT = 7;
  localparam int TX_ENABLE_BIT = 6;
  localparam int HANDSFREE_BIT = 2;
  localparam int SPEAKER_BIT = 1;
  localparam int EARPIECE_BIT = 0;
  localparam int POWER_BIT = 0;
  localparam int SERIAL_CMD_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_LAW_CLOCK_CONFIG = 8'h00;
  localparam logic [7:0] RESET_PATH_SELECT = 8'h00;
  localparam logic [7:0] RESET_TX_GAIN_SIDETONE = 8'h00;
  localparam logic [7:0] RESET_RX_ATTENUATION = 8'h00;
  localparam logic [7:0] RESET_TONE_LEVEL = 8'h00;
  localparam logic [7:0] READBACK_FILL = 8'h00;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLOCK_PERIOD_NS = 8;
  // Master clock counts as lost after this long without an edge
  localparam int MCLK_LOSS_NS = 4000;
  localparam int MCLK_LOSS_CYCLES = MCLK_LOSS_NS / CLOCK_PERIOD_NS;
  localparam int FS_PULSES_TO_TX = 2;
  localparam int SLOT_BITS = 8;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic mic_select;
    logic [3:0] tx_gain;
    logic [3:0] sidetone;
    logic sidetone_enable;
    logic tx_ground;
    logic [3:0] ear_atten;
    logic [3:0] speaker_atten;
    logic [3:0] tone_level;
    logic earpiece_route;
    logic speaker_route;
    logic handsfree_route;
    logic [1:0] law_select;
  } analog_ctrl_s;

  typedef struct packed {
    logic shift_clock;
    logic select_n;
    logic serial_in;
  } ctrl_port_s;

endpackage

//--- codec_ctrl_checker.sv
// Concurrent checks on the ports of the codec control block.
// Assumes one pclk domain with presetn as its asynchronous reset.
`timescale 1ns/1ps
module codec_ctrl_checker
  import codec_ctrl_pkg::*;
#(
  parameter int MCLK_LOSS_LIMIT = MCLK_LOSS_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ctrl_select_n,
  input wire logic ctrl_serial_out_oe_n,
  input wire logic master_bit_clock,
  input wire logic tx_data_out_oe_n,
  input wire logic open_drain_latch_out_oe_n,
  input wire logic powered_up,
  input wire analog_ctrl_s analog_ctrl
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic mapped;
  logic mclk_q;
  int idle;
  assign acc = psel && penable && pready && pwrite;
  assign mapped = paddr inside {ADDR_LAW_CLOCK_CONFIG, ADDR_PATH_SELECT, ADDR_TX_GAIN_SIDETONE,
    ADDR_RX_ATTENUATION, ADDR_TONE_LEVEL, ADDR_POWER_CTRL, ADDR_STATUS, ADDR_SERIAL_RX};
  // ----
  // Cycles since the raw master clock last moved
  // ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mclk_q <= 1'b0;
      idle <= 0;
    end else begin
      mclk_q <= master_bit_clock;
      idle <= (mclk_q != master_bit_clock) ? 0 : idle + 1;
    end
  end
  // Four cycles cover the select synchroniser
  serial_hiz_a: assert property (ctrl_select_n [*4] |-> ctrl_serial_out_oe_n)
    else $error("serial out driven while deselected");
  unmapped_err_a: assert property (psel && penable |-> pslverr == !mapped)
    else $error("error response wrong for address");
  power_down_a: assert property (acc && paddr == ADDR_POWER_CTRL && pwdata[0] |=> !powered_up)
    else $error("power down write ignored");
  path_fields_a: assert property (acc && paddr == ADDR_PATH_SELECT |=>
    analog_ctrl.mic_select == $past(pwdata[7]) && analog_ctrl.tx_ground ==
    (!$past(pwdata[6]) || !powered_up) && analog_ctrl.sidetone_enable ==
    ($past(pwdata[6]) && powered_up) && analog_ctrl.handsfree_route ==
    $past(pwdata[2]) && {analog_ctrl.speaker_route, analog_ctrl.earpiece_route} ==
    $past(pwdata[1:0]))
    else $error("path fields wrong");
  gain_fields_a: assert property (acc && paddr == ADDR_TX_GAIN_SIDETONE |=>
    {analog_ctrl.tx_gain, analog_ctrl.sidetone} == $past(pwdata[7:0]))
    else $error("gain fields wrong");
  atten_fields_a: assert property (acc && paddr == ADDR_RX_ATTENUATION |=>
    {analog_ctrl.ear_atten, analog_ctrl.speaker_atten} == $past(pwdata[7:0]))
    else $error("attenuation fields wrong");
  tone_level_a: assert property (acc && paddr == ADDR_TONE_LEVEL |=>
    analog_ctrl.tone_level == $past(pwdata[7:4]))
    else $error("tone level wrong");
  law_select_a: assert property (acc && paddr == ADDR_LAW_CLOCK_CONFIG |=>
    analog_ctrl.law_select == $past(pwdata[7:6]))
    else $error("law select wrong");
  mclk_loss_a: assert property (idle > MCLK_LOSS_LIMIT + 6 |->
    !powered_up && tx_data_out_oe_n && open_drain_latch_out_oe_n)
    else $error("lost master clock not handled");
  tx_hold_a: assert property ($rose(powered_up) |-> tx_data_out_oe_n [*8])
    else $error("transmit driven too soon");
endmodule

bind codec_serial_control_power codec_ctrl_checker #(.MCLK_LOSS_LIMIT(MCLK_LOSS_LIMIT)) chk_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
  .ctrl_select_n, .ctrl_serial_out_oe_n, .master_bit_clock, .tx_data_out_oe_n,
  .open_drain_latch_out_oe_n, .powered_up, .analog_ctrl);

//--- serial_host.sv
// Host controller model for the serial control port.
// Assumes its task is called at a pclk edge; the shift clock idles low.
`timescale 1ns/1ps
module serial_host (
  input wire logic pclk,
  output logic ctrl_shift_clock,
  output logic ctrl_select_n,
  output logic ctrl_serial_in,
  input wire logic ctrl_serial_out
);
  initial begin
    ctrl_shift_clock = 1'b0;
    ctrl_select_n = 1'b1;
    ctrl_serial_in = 1'b1;
  end
  // Two bytes in one select pulse; h is the half period in pclk cycles (5 = 40 ns)
  task automatic xfer(input logic [15:0] word, input int h, output logic [7:0] rdata);
    ctrl_select_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge pclk);
      ctrl_shift_clock <= 1'b0;
      ctrl_serial_in <= word[i];
      repeat (h) @(posedge pclk);
      ctrl_shift_clock <= 1'b1;
      if (i < 8) rdata[i] = ctrl_serial_out;
      repeat (h) @(posedge pclk);
    end
    ctrl_shift_clock <= 1'b0;
    repeat (h) @(posedge pclk);
    // A released line must not keep looking valid
    ctrl_select_n <= 1'b1;
    ctrl_serial_in <= ~ctrl_serial_in;
    @(posedge pclk);
  endtask
endmodule

//--- testbench.sv
// Self-checking bench for the codec control block over APB and the serial port.
// Assumes the host model and the bound port checker.
`timescale 1ns/1ps
module testbench import codec_ctrl_pkg::*;;
  localparam int LOSS = 20;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, mclk_run;
  logic [7:0] paddr, encoded_sample, d, rd8;
  logic [31:0] pwdata, prdata;
  logic ctrl_shift_clock, ctrl_select_n, ctrl_serial_in, ctrl_serial_out, ctrl_serial_out_oe_n;
  logic [3:0] bus_address_straps;
  logic interface_select_strap, master_bit_clock, frame_sync, rx_data_in, bad;
  logic tx_data_out_oe_n, open_drain_latch_out_oe_n, powered_up;
  logic [64:0] q[$];
  logic [64:0] e;
  logic [7:0] regs[5] = '{ADDR_LAW_CLOCK_CONFIG, ADDR_PATH_SELECT, ADDR_TX_GAIN_SIDETONE,
    ADDR_RX_ATTENUATION, ADDR_TONE_LEVEL};
  int num_errors = 0;
  int num_checks = 0;
  int mdiv = 0;
  int fcnt = 0;
  int n;
  codec_serial_control_power #(.MCLK_LOSS_LIMIT(LOSS)) DUT (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ctrl_shift_clock,
    .ctrl_select_n, .ctrl_serial_in, .ctrl_serial_out, .ctrl_serial_out_oe_n,
    .bus_address_straps, .interface_select_strap, .master_bit_clock, .frame_sync,
    .rx_data_in, .tx_data_out(), .tx_data_out_oe_n, .open_drain_latch_out(),
    .open_drain_latch_out_oe_n, .encoded_sample, .received_sample(), .received_valid(),
    .powered_up, .analog_ctrl());
  serial_host host (.pclk, .ctrl_shift_clock, .ctrl_select_n, .ctrl_serial_in,
    .ctrl_serial_out);
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    if (num_errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ----
  // APB master: entered at an edge, leaves one idle cycle
  // ----
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) begin
      num_errors++;
      end_sim();
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m,
      input logic err);
    q.push_back({err, m, x});
    apb(1'b0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) begin
      e = q.pop_front();
      chk(prdata & e[63:32], e[31:0]);
      chk(32'(pslverr), 32'(e[64]));
    end
  end
  // Master bit clock and frame sync; frames of 64 bits
  always @(posedge pclk) begin
    if (mclk_run) begin
      mdiv <= (mdiv == 5) ? 0 : mdiv + 1;
      if (mdiv == 5) begin
        master_bit_clock <= ~master_bit_clock;
        if (master_bit_clock) begin
          fcnt <= (fcnt + 1) % 64;
          frame_sync <= (fcnt < 2);
          rx_data_in <= 1'($urandom);
        end
      end
    end
  end
  initial begin
    void'($urandom(73161));
    bus_address_straps = 4'($urandom);
    encoded_sample = 8'($urandom);
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {clk_en, interface_select_strap, mclk_run} = 3'b111;
    {master_bit_clock, frame_sync, rx_data_in} = 3'b000;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    foreach (regs[i]) rd(regs[i], 32'h0, 32'hff, 1'b0);
    rd(ADDR_STATUS, {25'h0, 3'b100, bus_address_straps}, 32'h4f, 1'b0);
    rd(8'h04, 32'h0, 32'hffffffff, 1'b1);
    chk(32'(powered_up), 32'h0);
    // Program every law code while powered down
    for (int k = 0; k < 4; k++) begin
      foreach (regs[i]) begin
        d = 8'($urandom);
        if (i == 0) d = {k[1:0], d[5:1], 1'b0};
        apb(1'b1, regs[i], {24'h0, d});
        rd(regs[i], {24'h0, d}, 32'hff, 1'b0);
      end
    end
    d = 8'($urandom);
    host.xfer({8'h80, d}, 5, rd8);
    repeat (6) @(posedge pclk);
    rd(ADDR_PATH_SELECT, {24'h0, d}, 32'hff, 1'b0);
    chk(32'(powered_up), 32'h1);
    n = 0;
    bad = 1'b0;
    while (frame_sync !== 1'b1 && n < 2000) begin
      @(posedge pclk);
      n++;
    end
    repeat (100) begin
      @(posedge pclk);
      bad |= (tx_data_out_oe_n !== 1'b1);
    end
    chk(32'(bad), 32'(n >= 2000));
    // Slow host reads the path register back and powers down
    host.xfer(16'h8300, 9, rd8);
    chk(32'(rd8), 32'(d));
    repeat (6) @(posedge pclk);
    chk(32'(powered_up), 32'h0);
    apb(1'b1, ADDR_POWER_CTRL, 32'h0);
    chk(32'(powered_up), 32'h1);
    apb(1'b1, ADDR_POWER_CTRL, 32'h1);
    rd(ADDR_PATH_SELECT, {24'h0, d}, 32'hff, 1'b0);
    host.xfer(16'h2020, 5, rd8);
    repeat (6) @(posedge pclk);
    chk(32'(powered_up), 32'h1);
    apb(1'b1, ADDR_LAW_CLOCK_CONFIG, 32'h1);
    apb(1'b1, ADDR_POWER_CTRL, 32'h0);
    chk(32'(open_drain_latch_out_oe_n), 32'h0);
    mclk_run <= 1'b0;
    repeat (LOSS + 20) @(posedge pclk);
    chk(32'({powered_up, tx_data_out_oe_n, open_drain_latch_out_oe_n}), 32'h3);
    interface_select_strap <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
    rd(ADDR_STATUS, 32'h0, 32'h40, 1'b0);
    chk(32'(powered_up), 32'h0);
    end_sim();
  end
endmodule
